/* File: rtl/otp_host_regs.svh */
// Timing and field constants for the one-time PROM programming host
`ifndef OTP_HOST_REGS_SVH
`define OTP_HOST_REGS_SVH

`define CLK_PERIOD_NS 20

// Address, data, select and supply setup and hold times are all 1 us minimum
`define SETUP_NS 1000
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Nominal program pulse; the window is 95 to 105 us
`define PULSE_NS 100000
`define PULSE_CYC (`PULSE_NS / `CLK_PERIOD_NS)

// Slowest speed grade access time, also covers the verify gate delay
`define ACCESS_NS 250
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Output float after gate or select goes high
`define FLOAT_NS 60
`define FLOAT_CYC ((`FLOAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define MAX_PULSES 25
`define ERASED_BYTE 8'hff
`define BYTE_W 8

`endif

/* File: rtl/otp_host_pkg.sv */
// Types shared by the PROM programming host
package otp_host_pkg;

   typedef enum logic [4:0] {
      S_IDLE,
      S_RD_TOGGLE,
      S_RD_ADDR,
      S_RD_GATE,
      S_RD_END,
      S_PG_FETCH,
      S_PG_SUPPLY,
      S_PG_ARM,
      S_PG_SETUP,
      S_PG_PULSE,
      S_PG_HOLD,
      S_PG_VSEL,
      S_PG_VREAD,
      S_PG_VFLOAT,
      S_PG_VNEXT,
      S_PG_NEXT,
      S_PG_DOWN,
      S_PG_END
   } ctl_state_t;

endpackage

/* File: rtl/wait_timer.sv */
// Reloadable down-counter timing every pin phase of the host
`timescale 1ns/10ps
module wait_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Load a wait of load_val cycles
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // High once the loaded wait has run out
   output logic expired
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_t;

   tmr_t s_q;
   tmr_t s_d;

   if (W < 2) begin : g_bad_width
      $error("wait_timer needs at least two counter bits");
   end

   always_comb begin
      s_d = s_q;
      if (load) begin
         // Minus one so the phase lasts exactly load_val cycles
         s_d.cnt = load_val - W'(1);
      end else if (s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expired = (s_q.cnt == '0);

endmodule

/* File: rtl/otp_prom_host.sv */
// Host controller that reads and programs one-time PROMs through their pins
//
// Summary of operation
// RQ1: Device drives data only when selected, gated, unstrobed
// RQ2: Six modes follow from select, gate, strobe, supply
// RQ3: Program strobe stays high except during pulses
// RQ4: Read data valid gate delay after gate falls
// RQ5: After supply dip, change address before reading; an id read after a dip keeps its address
// RQ6: Select high puts device in standby, outputs float
// RQ7: Gate or select high floats the data pins
// RQ8: Decode select per device, gate shared by all
// RQ9: Blank cells read one; only zeros get programmed
// RQ10: Programmed zeros never return to one
// RQ11: Program only with high supply, gate high, selected
// RQ12: Raise both supplies for programming, lower afterwards
// RQ13: Present the whole byte in parallel while programming
// RQ14: One low strobe pulse per address, data stable; the code gives an address up to 25 pulses
// RQ15: Repeat 100 us pulses until verify, at most 25
// RQ16: Each pulse lasts 95 to 105 us
// RQ17: Never hold the strobe low as a level
// RQ18: Shared strobe programs all devices with same data
// RQ19: Verify read back while supply stays raised
// RQ20: Select high inhibits a device sharing the strobe
// RQ21: Raised id line reads maker or device code
// RQ22: Flag failure and stop at pulse limit
// RQ23: Step addresses in order, skip all-ones bytes
`timescale 1ns/10ps
`include "otp_host_regs.svh"
module otp_prom_host #(
   parameter int ADDR_W = 13,
   parameter int NUM_DEV = 4,
   parameter int PULSE_CYCLES = `PULSE_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Commands
   input wire logic CMD_READ,
   input wire logic CMD_ID,
   input wire logic CMD_PROG,
   input wire logic [ADDR_W-1:0] CMD_ADDR,
   input wire logic [ADDR_W-1:0] CMD_END_ADDR,
   input wire logic [((NUM_DEV > 1) ? $clog2(NUM_DEV) : 1)-1:0] CMD_DEV,
   input wire logic [NUM_DEV-1:0] CMD_DEV_MASK,
   input wire logic VCC_DIP,
   // Status and read result
   output logic BUSY,
   output logic DONE,
   output logic FAIL,
   output logic [NUM_DEV-1:0] FAIL_MASK,
   output logic [`BYTE_W-1:0] RD_DATA,
   // Image fetch
   output logic FETCH_REQ,
   output logic [ADDR_W-1:0] FETCH_ADDR,
   input wire logic FETCH_VALID,
   input wire logic [`BYTE_W-1:0] FETCH_DATA,
   // PROM pins
   output logic [ADDR_W-1:0] WORD_SELECT_LINES,
   output logic [NUM_DEV-1:0] CHIP_SEL_N,
   output logic OUTPUT_GATE_N,
   output logic PROGRAM_STROBE_N,
   input wire logic [`BYTE_W-1:0] BYTE_LINES_I,
   output logic [`BYTE_W-1:0] BYTE_LINES_O,
   output logic BYTE_LINES_OE,
   // Supply and id line level requests
   output logic VPP_PROG_LEVEL,
   output logic VCC_PROG_LEVEL,
   output logic ID_SELECT_LINE_HV
);

   localparam int DEV_W = (NUM_DEV > 1) ? $clog2(NUM_DEV) : 1;
   localparam int TW = 16;
   localparam int DOWN_WAIT = 2;
   localparam logic [TW-1:0] T_SET = TW'(`SETUP_CYC);
   localparam logic [TW-1:0] T_ACC = TW'(`ACCESS_CYC);
   localparam logic [TW-1:0] T_FLT = TW'(`FLOAT_CYC);
   localparam logic [TW-1:0] T_PULSE = TW'(PULSE_CYCLES);

   if (NUM_DEV < 1 || NUM_DEV > 8 || ADDR_W < 2 || ADDR_W > 16) begin : g_bad_shape
      $error("otp_prom_host: unsupported device count or address width");
   end
   if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << TW)) begin : g_bad_pulse
      $error("otp_prom_host: pulse length does not fit the timer");
   end

   typedef struct packed {
      otp_host_pkg::ctl_state_t st;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] last;
      logic [`BYTE_W-1:0] want;
      logic [4:0] pulses;
      logic [DEV_W-1:0] dev;
      logic [NUM_DEV-1:0] mask;
      logic [NUM_DEV-1:0] pend;
      logic [NUM_DEV-1:0] failm;
      logic dip;
      logic [NUM_DEV-1:0] ce_n;
      logic oe_n;
      logic pgm_n;
      logic [ADDR_W-1:0] a;
      logic [`BYTE_W-1:0] dq_o;
      logic dq_oe;
      logic vpp;
      logic vcc;
      logic idhv;
      logic busy;
      logic done;
      logic fail;
      logic freq;
      logic [`BYTE_W-1:0] rdata;
      logic [TW-1:0] lowc;
   } ctl_t;

   ctl_t s_q;
   ctl_t s_d;
   logic tload;
   logic [TW-1:0] tval;
   logic t_exp;

   // Only the addressed device sees select low
   function automatic logic [NUM_DEV-1:0] sel_n(input logic [DEV_W-1:0] idx);
      logic [NUM_DEV-1:0] v;
      v = '1;
      v[idx] = 1'b0;
      return v;
   endfunction

   wait_timer #(
      .W(TW)
   ) u_timer (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .load(tload),
      .load_val(tval),
      .expired(t_exp)
   );

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      tload = 1'b0;
      tval = '0;
      unique case (s_q.st)
         otp_host_pkg::S_IDLE: begin
            if (CMD_PROG) begin
               s_d.busy = 1'b1;
               s_d.fail = 1'b0;
               s_d.failm = '0;
               s_d.addr = CMD_ADDR;
               s_d.last = CMD_END_ADDR;
               s_d.mask = CMD_DEV_MASK; // [RQ18]
               s_d.pend = CMD_DEV_MASK;
               s_d.freq = 1'b1;
               s_d.st = otp_host_pkg::S_PG_FETCH;
            end else if (CMD_READ || CMD_ID) begin
               s_d.busy = 1'b1;
               s_d.fail = 1'b0;
               s_d.addr = CMD_ADDR;
               s_d.ce_n = sel_n(CMD_DEV); // [RQ8] [RQ6]
               s_d.oe_n = 1'b1;
               s_d.idhv = CMD_ID; // [RQ21]
               tload = 1'b1;
               if (CMD_ID) begin
                  // Code select uses the lowest line alone
                  s_d.a = ADDR_W'(CMD_ADDR[0]); // [RQ21]
                  tval = T_SET;
                  s_d.st = otp_host_pkg::S_RD_ADDR;
               end else if (s_q.dip) begin
                  // Sense amps need an address change after a dip
                  s_d.a = CMD_ADDR ^ ADDR_W'(1); // [RQ5]
                  s_d.dip = 1'b0;
                  tval = T_ACC;
                  s_d.st = otp_host_pkg::S_RD_TOGGLE;
               end else begin
                  s_d.a = CMD_ADDR;
                  tval = T_ACC;
                  s_d.st = otp_host_pkg::S_RD_ADDR;
               end
            end
         end
         otp_host_pkg::S_RD_TOGGLE: begin
            if (t_exp) begin
               s_d.a = s_q.addr; // [RQ5]
               tload = 1'b1;
               tval = T_ACC;
               s_d.st = otp_host_pkg::S_RD_ADDR;
            end
         end
         otp_host_pkg::S_RD_ADDR: begin
            if (t_exp) begin
               s_d.oe_n = 1'b0; // [RQ1]
               tload = 1'b1;
               tval = T_ACC;
               s_d.st = otp_host_pkg::S_RD_GATE;
            end
         end
         otp_host_pkg::S_RD_GATE: begin
            if (t_exp) begin
               s_d.rdata = BYTE_LINES_I; // [RQ4]
               s_d.oe_n = 1'b1; // [RQ7]
               s_d.ce_n = '1;
               s_d.idhv = 1'b0;
               tload = 1'b1;
               tval = T_FLT;
               s_d.st = otp_host_pkg::S_RD_END;
            end
         end
         otp_host_pkg::S_RD_END: begin
            if (t_exp) begin
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.st = otp_host_pkg::S_IDLE;
            end
         end
         otp_host_pkg::S_PG_FETCH: begin
            if (FETCH_VALID) begin
               s_d.freq = 1'b0;
               s_d.want = FETCH_DATA;
               s_d.pulses = '0;
               if (FETCH_DATA == `ERASED_BYTE) begin
                  // Blank cells already read as ones
                  s_d.st = otp_host_pkg::S_PG_NEXT; // [RQ23] [RQ9]
               end else if (!s_q.vpp) begin
                  s_d.vcc = 1'b1; // [RQ12]
                  s_d.vpp = 1'b1;
                  tload = 1'b1;
                  tval = T_SET;
                  s_d.st = otp_host_pkg::S_PG_SUPPLY;
               end else begin
                  s_d.st = otp_host_pkg::S_PG_ARM;
               end
            end
         end
         otp_host_pkg::S_PG_SUPPLY: begin
            if (t_exp) begin
               s_d.st = otp_host_pkg::S_PG_ARM;
            end
         end
         otp_host_pkg::S_PG_ARM: begin
            s_d.a = s_q.addr;
            s_d.ce_n = ~s_q.pend; // [RQ20] [RQ11]
            s_d.oe_n = 1'b1; // [RQ11]
            s_d.dq_o = s_q.want; // [RQ13]
            s_d.dq_oe = 1'b1;
            tload = 1'b1;
            tval = T_SET;
            s_d.st = otp_host_pkg::S_PG_SETUP;
         end
         otp_host_pkg::S_PG_SETUP: begin
            if (t_exp) begin
               s_d.pgm_n = 1'b0; // [RQ14] [RQ18]
               s_d.pulses = s_q.pulses + 5'd1;
               tload = 1'b1;
               tval = T_PULSE; // [RQ16]
               s_d.st = otp_host_pkg::S_PG_PULSE;
            end
         end
         otp_host_pkg::S_PG_PULSE: begin
            if (t_exp) begin
               s_d.pgm_n = 1'b1; // [RQ17] [RQ3]
               tload = 1'b1;
               tval = T_SET;
               s_d.st = otp_host_pkg::S_PG_HOLD;
            end
         end
         otp_host_pkg::S_PG_HOLD: begin
            if (t_exp) begin
               s_d.dq_oe = 1'b0;
               s_d.ce_n = '1;
               s_d.dev = '0;
               s_d.st = otp_host_pkg::S_PG_VSEL;
            end
         end
         otp_host_pkg::S_PG_VSEL: begin
            if (s_q.pend[s_q.dev]) begin
               // Supplies stay raised through verify
               s_d.ce_n = sel_n(s_q.dev); // [RQ19] [RQ2]
               s_d.oe_n = 1'b0;
               tload = 1'b1;
               tval = T_ACC;
               s_d.st = otp_host_pkg::S_PG_VREAD;
            end else begin
               s_d.st = otp_host_pkg::S_PG_VNEXT;
            end
         end
         otp_host_pkg::S_PG_VREAD: begin
            if (t_exp) begin
               if (BYTE_LINES_I == s_q.want) begin
                  s_d.pend[s_q.dev] = 1'b0; // [RQ15]
               end
               s_d.oe_n = 1'b1;
               s_d.ce_n = '1;
               tload = 1'b1;
               tval = T_FLT;
               s_d.st = otp_host_pkg::S_PG_VFLOAT;
            end
         end
         otp_host_pkg::S_PG_VFLOAT: begin
            if (t_exp) begin
               s_d.st = otp_host_pkg::S_PG_VNEXT;
            end
         end
         otp_host_pkg::S_PG_VNEXT: begin
            if (s_q.dev != DEV_W'(NUM_DEV - 1)) begin
               s_d.dev = s_q.dev + DEV_W'(1);
               s_d.st = otp_host_pkg::S_PG_VSEL;
            end else if (s_q.pend == '0) begin
               s_d.st = otp_host_pkg::S_PG_NEXT;
            end else if (s_q.pulses == 5'(`MAX_PULSES)) begin
               // A zero can never be undone, so retrying is pointless
               s_d.failm = s_q.pend; // [RQ22] [RQ10]
               s_d.fail = 1'b1;
               s_d.st = otp_host_pkg::S_PG_DOWN;
            end else begin
               s_d.st = otp_host_pkg::S_PG_ARM; // [RQ15]
            end
         end
         otp_host_pkg::S_PG_NEXT: begin
            if (s_q.addr == s_q.last) begin
               s_d.st = otp_host_pkg::S_PG_DOWN;
            end else begin
               s_d.addr = s_q.addr + ADDR_W'(1); // [RQ23]
               s_d.pend = s_q.mask;
               s_d.freq = 1'b1;
               s_d.st = otp_host_pkg::S_PG_FETCH;
            end
         end
         otp_host_pkg::S_PG_DOWN: begin
            s_d.ce_n = '1;
            s_d.oe_n = 1'b1;
            s_d.dq_oe = 1'b0;
            s_d.vpp = 1'b0; // [RQ12]
            s_d.vcc = 1'b0;
            tload = 1'b1;
            tval = T_SET;
            s_d.st = otp_host_pkg::S_PG_END;
         end
         otp_host_pkg::S_PG_END: begin
            if (t_exp) begin
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.st = otp_host_pkg::S_IDLE;
            end
         end
         default: begin
            s_d.st = otp_host_pkg::S_PG_DOWN;
         end
      endcase
      // A dip in the same cycle as the clear is kept
      s_d.dip = s_d.dip | VCC_DIP; // [RQ5]
      s_d.lowc = s_q.pgm_n ? '0 : s_q.lowc + TW'(1);
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q <= '{st: otp_host_pkg::S_IDLE, ce_n: '1, oe_n: 1'b1, pgm_n: 1'b1,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign BUSY = s_q.busy;
   assign DONE = s_q.done;
   assign FAIL = s_q.fail;
   assign FAIL_MASK = s_q.failm;
   assign RD_DATA = s_q.rdata;
   assign FETCH_REQ = s_q.freq;
   assign FETCH_ADDR = s_q.addr;
   assign WORD_SELECT_LINES = s_q.a;
   assign CHIP_SEL_N = s_q.ce_n;
   assign OUTPUT_GATE_N = s_q.oe_n;
   assign PROGRAM_STROBE_N = s_q.pgm_n;
   assign BYTE_LINES_O = s_q.dq_o;
   assign BYTE_LINES_OE = s_q.dq_oe;
   assign VPP_PROG_LEVEL = s_q.vpp;
   assign VCC_PROG_LEVEL = s_q.vcc;
   assign ID_SELECT_LINE_HV = s_q.idhv;

   a_strobe_idle_high: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ3]
      !s_q.busy |-> s_q.pgm_n)
      else $error("program strobe low while idle");

   a_pulse_exact_width: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ16]
      $rose(s_q.pgm_n) |-> s_q.lowc == T_PULSE)
      else $error("program pulse width wrong");

   a_pulse_supplies: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ11]
      !s_q.pgm_n |-> s_q.vpp && s_q.vcc && s_q.oe_n && (s_q.ce_n != '1))
      else $error("pulse without programming conditions");

   a_pulse_data_held: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ13]
      $fell(s_q.pgm_n) |-> s_q.dq_oe && s_q.dq_o == s_q.want && $stable(s_q.a)
      ##1 (s_q.dq_oe && $stable(s_q.dq_o)))
      else $error("data not stable around pulse");

   a_pulse_limit: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ15]
      s_q.pulses <= 5'(`MAX_PULSES))
      else $error("pulse count above limit");

   a_no_contention: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ7]
      s_q.dq_oe |-> s_q.oe_n)
      else $error("host drives data while gate low");

   a_one_selected: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ8]
      !s_q.oe_n |-> $onehot(~s_q.ce_n))
      else $error("read with not exactly one select low");

   a_skip_erased: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ23]
      (s_q.st == otp_host_pkg::S_PG_FETCH && FETCH_VALID && FETCH_DATA == `ERASED_BYTE)
      |=> s_q.st == otp_host_pkg::S_PG_NEXT ##1 s_q.pgm_n)
      else $error("all-ones byte not skipped");

   a_fail_stops: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RQ22]
      $rose(s_q.fail) |-> ##[1:DOWN_WAIT] (!s_q.vpp && !s_q.vcc))
      else $error("supplies not lowered after failure");

endmodule

/* File: tb/prom_dev.sv */
// Behavioural one-time PROM device that answers the host's pins
`timescale 1ns/10ps
module prom_dev #(
   parameter real PW_NS = 400.0,
   parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'hc3 // Arbitrary value
) (
   // Pins
   input wire logic [12:0] addr,
   input wire logic sel_n,
   input wire logic gate_n,
   input wire logic strobe_n,
   input wire logic [7:0] din,
   input wire logic vpp_hi,
   input wire logic vcc_hi,
   input wire logic id_hv,
   // Model controls
   input wire logic [4:0] need_pulses,
   input wire logic [12:0] stuck_addr,
   // Read side and fault count
   output logic [7:0] dout,
   output logic doe,
   output logic [7:0] errs
);
   logic [7:0] mem [0:8191];
   int hits [0:8191];
   realtime t_fall;
   logic [7:0] d_fall;

   initial begin
      errs = 8'h00;
      foreach (mem[i]) begin
         mem[i] = 8'hff;
         hits[i] = 0;
      end
   end

   assign doe = !sel_n && !gate_n && strobe_n;
   assign dout = id_hv ? (addr[0] ? PART_CODE : MAKER_CODE) : mem[addr];

   // A strobe without the raised supplies would be a stray write
   always @(negedge strobe_n) begin
      t_fall = $realtime;
      d_fall = din;
      if (!vpp_hi || !vcc_hi) errs++;
   end

   // Cells settle only after the required pulse count, stuck cells never
   always @(posedge strobe_n) begin
      if (!sel_n && gate_n && vpp_hi && vcc_hi) begin
         if ($realtime - t_fall < PW_NS * 0.95) errs++;
         if ($realtime - t_fall > PW_NS * 1.05) errs++;
         if (din !== d_fall) errs++;
         hits[addr]++;
         if (hits[addr] >= need_pulses && addr != stuck_addr)
            mem[addr] = mem[addr] & din;
      end
   end
endmodule

/* File: tb/otp_prom_host_bench.sv */
// Self-checking bench for the PROM host driving two behavioural devices
`timescale 1ns/10ps
`define CHK(what, got, exp) \
   total_checks++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
   end
module otp_prom_host_bench;
   localparam int PW = 20;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
   localparam logic [7:0] PART = 8'hc3; // Arbitrary value
   logic ref_clk = 0, rst_n = 0, cmd_read = 0, cmd_id = 0, cmd_prog = 0, vcc_dip = 0;
   logic [12:0] cmd_addr = 0, cmd_end = 0;
   logic [0:0] cmd_dev = 0;
   logic [1:0] cmd_mask = 0;
   logic fetch_valid = 0;
   logic [7:0] fetch_data = 0, float_q = 8'h5a;
   logic [4:0] need = 5'd3;
   logic [12:0] stuck [2] = '{13'h1fff, 13'h1fff};
   wire busy, done, fail, fetch_req, gate_n, strobe_n, byte_oe, vpp_hi, vcc_hi, id_hv;
   wire [1:0] fail_mask, sel_n, doe;
   wire [7:0] rd_data, byte_o, byte_bus;
   wire [7:0] dout [2];
   wire [7:0] errs [2];
   wire [12:0] fetch_addr, word_sel;
   int bad_count = 0, total_checks = 0, pulses = 0;

   initial forever #10 ref_clk = ~ref_clk;

   otp_prom_host #(.ADDR_W(13), .NUM_DEV(2), .PULSE_CYCLES(PW)) u_otp_prom_host (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CMD_READ(cmd_read), .CMD_ID(cmd_id),
      .CMD_PROG(cmd_prog), .CMD_ADDR(cmd_addr), .CMD_END_ADDR(cmd_end), .CMD_DEV(cmd_dev),
      .CMD_DEV_MASK(cmd_mask), .VCC_DIP(vcc_dip), .BUSY(busy), .DONE(done), .FAIL(fail),
      .FAIL_MASK(fail_mask), .RD_DATA(rd_data), .FETCH_REQ(fetch_req),
      .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data),
      .WORD_SELECT_LINES(word_sel), .CHIP_SEL_N(sel_n), .OUTPUT_GATE_N(gate_n),
      .PROGRAM_STROBE_N(strobe_n), .BYTE_LINES_I(byte_bus), .BYTE_LINES_O(byte_o),
      .BYTE_LINES_OE(byte_oe), .VPP_PROG_LEVEL(vpp_hi), .VCC_PROG_LEVEL(vcc_hi),
      .ID_SELECT_LINE_HV(id_hv));

   for (genvar g = 0; g < 2; g++) begin : g_dev
      prom_dev #(.PW_NS(PW * 20.0), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_prom_dev (
         .addr(word_sel), .sel_n(sel_n[g]), .gate_n(gate_n), .strobe_n(strobe_n),
         .din(byte_bus), .vpp_hi(vpp_hi), .vcc_hi(vcc_hi), .id_hv(id_hv),
         .need_pulses(need), .stuck_addr(stuck[g]), .dout(dout[g]), .doe(doe[g]),
         .errs(errs[g]));
   end

   // Undriven bus flips every cycle so a stale byte never reads as valid
   assign byte_bus = byte_oe ? byte_o : doe[0] ? dout[0] : doe[1] ? dout[1] : float_q;
   always @(posedge ref_clk) float_q <= ~float_q;
   // Looked at mid-cycle, away from the edge that moves the pins
   always @(negedge ref_clk) if (rst_n) begin
      `CHK("bus drivers", (doe[0] && doe[1]) || (byte_oe && |doe), 1'b0)
   end
   always @(negedge strobe_n) pulses++;

   function automatic logic [7:0] img(input logic [12:0] a);
      return (a[1:0] == 2'd2) ? 8'hff : 8'h5a ^ a[7:0];
   endfunction

   // Image source answers one cycle after each request
   always @(negedge ref_clk) begin
      fetch_valid <= fetch_req && !fetch_valid;
      fetch_data <= img(fetch_addr);
   end

   task automatic conclude();
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic issue(input logic rd, id, pg, input logic [12:0] a, e);
      @(negedge ref_clk);
      cmd_read = rd;
      cmd_id = id;
      cmd_prog = pg;
      cmd_addr = a;
      cmd_end = e;
      @(negedge ref_clk);
      cmd_read = 0;
      cmd_id = 0;
      cmd_prog = 0;
   endtask

   task automatic wait_done(output int cyc);
      cyc = 1;
      while (done !== 1'b1) begin
         if (cyc > 20000) begin
            bad_count++;
            $display("Error DONE expected 1 seen timeout");
            conclude();
         end
         @(negedge ref_clk);
         cyc++;
      end
   endtask

   task automatic do_read(input logic dev, input logic [12:0] a, a1, input logic [7:0] exp,
                          input int cyc_exp);
      int cyc;
      cmd_dev = dev;
      issue(1, 0, 0, a, a);
      `CHK("select", sel_n, dev ? 2'b01 : 2'b10)
      `CHK("first address", word_sel, a1)
      `CHK("busy while reading", busy, 1'b1)
      wait_done(cyc);
      `CHK("read cycles", cyc, cyc_exp)
      `CHK("busy after done", busy, 1'b0)
      `CHK("read data", rd_data, exp)
      `CHK("idle gate", gate_n, 1'b1)
   endtask

   task automatic do_id(input logic a0, input logic [7:0] exp);
      int cyc;
      cmd_dev = 0;
      issue(0, 1, 0, {12'h000, a0}, 13'h0000);
      wait_done(cyc);
      `CHK("id code", rd_data, exp)
      `CHK("id line released", id_hv, 1'b0)
   endtask

   task automatic do_prog(input logic [1:0] mask, input logic [12:0] a, e, input int np,
                          input logic f, input logic [1:0] fm);
      int cyc;
      cmd_mask = mask;
      pulses = 0;
      issue(0, 0, 1, a, e);
      wait_done(cyc);
      `CHK("pulse count", pulses, np)
      `CHK("fail", fail, f)
      `CHK("fail mask", fail_mask, fm)
      `CHK("fetch request idle", fetch_req, 1'b0)
      `CHK("device faults", {errs[0], errs[1]}, 16'h0000)
      `CHK("supply lowered", {vpp_hi, vcc_hi, sel_n}, 4'b0011)
   endtask

   initial begin
      repeat (16) @(negedge ref_clk);
      rst_n = 1;
      `CHK("reset pins", {sel_n, gate_n, strobe_n, byte_oe, vpp_hi}, 6'b111100)
      do_read(0, 13'h0010, 13'h0010, 8'hff, 30);
      do_prog(2'b01, 13'h0010, 13'h0012, 6, 1'b0, 2'b00);
      do_read(0, 13'h0010, 13'h0010, 8'h4a, 30);
      do_read(0, 13'h0012, 13'h0012, 8'hff, 30);
      do_read(1, 13'h0010, 13'h0010, 8'hff, 30);
      @(negedge ref_clk);
      vcc_dip = 1;
      @(negedge ref_clk);
      vcc_dip = 0;
      do_read(0, 13'h0011, 13'h0010, 8'h4b, 43);
      do_id(1'b0, MAKER);
      do_id(1'b1, PART);
      stuck[1] = 13'h0021;
      do_prog(2'b11, 13'h0020, 13'h0023, 28, 1'b1, 2'b10);
      `CHK("failing address", fetch_addr, 13'h0021)
      do_read(1, 13'h0020, 13'h0020, 8'h7a, 30);
      do_read(0, 13'h0021, 13'h0021, 8'h7b, 30);
      conclude();
   end
endmodule
